// >>> include/epc_pkg.sv
package epc_pkg;
  localparam int EPC_WIDTH = 80;
  localparam int EPC_FRAC_W = 63;
  localparam int EPC_EXP_W = 15;
  localparam int EPC_SIGN_POS = 79;
  localparam int EPC_EXP_LSB = 64;
  localparam int EPC_INT_POS = 63;
  localparam int EPC_FRAC_TOP = 62;
  localparam int EPC_NREGS = 8;
  localparam int EPC_IDX_W = 3;
  localparam logic [14:0] EPC_EXP_ONES = 15'h7FFF;
  localparam logic [14:0] EPC_EXP_ZERO = 15'h0000;
  localparam logic [7:0] EPC_ESCAPE_LO = 8'hD8;
  localparam logic [7:0] EPC_ESCAPE_HI = 8'hDF;
  localparam logic [2:0] EPC_TOP_RESET = 3'h0;
  localparam logic [1:0] EPC_SRC_NONE = 2'h0;
  localparam logic [1:0] EPC_SRC_REG = 2'h1;
  localparam logic [1:0] EPC_SRC_MEM = 2'h2;
  localparam logic [1:0] EPC_SRC_IMM = 2'h3;
  // one-hot operand class
  typedef enum logic [7:0] {
    EPC_CL_ZERO = 8'h01,
    EPC_CL_DENORM = 8'h02,
    EPC_CL_NORMAL = 8'h04,
    EPC_CL_INF = 8'h08,
    EPC_CL_NAN = 8'h10,
    EPC_CL_PSEUDO_NAN = 8'h20,
    EPC_CL_PSEUDO_INF = 8'h40,
    EPC_CL_UNNORMAL = 8'h80
  } epc_class_t;
endpackage

// >>> hw/epc_classify.sv
module epc_classify
  import epc_pkg::*;
(
  // operand
  input wire logic [79:0] operand,
  // class
  output epc_class_t op_class,
  output logic pseudo_denorm,
  output logic quiet
);
  logic [14:0] exp_f;
  logic int_b;
  logic [62:0] frac;
  assign exp_f = operand[EPC_SIGN_POS-1:EPC_EXP_LSB];
  assign int_b = operand[EPC_INT_POS];
  assign frac = operand[EPC_FRAC_TOP:0];
  assign quiet = operand[EPC_FRAC_TOP];
  assign pseudo_denorm = (exp_f == EPC_EXP_ZERO) && int_b;
  always_comb begin
    if (exp_f == EPC_EXP_ONES) begin
      if (!int_b) begin
        op_class = (frac != '0) ? EPC_CL_PSEUDO_NAN : EPC_CL_PSEUDO_INF;
      end else begin
        op_class = (frac != '0) ? EPC_CL_NAN : EPC_CL_INF;
      end
    end else if (exp_f == EPC_EXP_ZERO) begin
      op_class = (int_b || frac != '0) ? EPC_CL_DENORM : EPC_CL_ZERO;
    end else begin
      op_class = int_b ? EPC_CL_NORMAL : EPC_CL_UNNORMAL;
    end
  end
endmodule

// >>> hw/epc_operand_screen.sv
module epc_operand_screen
  import epc_pkg::*;
#(
  parameter int NREGS = EPC_NREGS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // decoder request
  input wire logic req_valid,
  input wire logic [7:0] opcode_byte,
  input wire logic [1:0] num_ops,
  input wire logic [1:0] src_a,
  input wire logic [1:0] src_b,
  input wire logic [2:0] idx_a,
  input wire logic [2:0] idx_b,
  input wire logic [79:0] mem_a,
  input wire logic [79:0] mem_b,
  input wire logic push,
  input wire logic [79:0] push_value,
  input wire logic pop,
  // result from datapath
  input wire logic res_valid,
  input wire logic [79:0] res_value,
  // to datapath and exception logic
  output logic out_valid,
  output logic float_escape_opcode_class,
  output logic [79:0] opnd_a,
  output logic [79:0] opnd_b,
  output logic [7:0] class_a,
  output logic [7:0] class_b,
  output logic invalid_exc,
  output logic denormal_exc,
  output logic source_fault,
  output logic [79:0] res_out,
  output logic res_out_valid,
  output logic [2:0] stack_top,
  output logic [7:0] reg_empty
);
  logic [79:0] regs [NREGS];
  logic [79:0] val_a, val_b, res_fixed;
  epc_class_t cl_a, cl_b;
  logic pd_a, pd_b, use_a, use_b, escape_hit, bad_src, known_a, known_b, quiet_a;
  logic [2:0] next_top;

  function automatic logic [2:0] phys(input logic [2:0] top, input logic [2:0] rel);
    phys = top + rel;
  endfunction

  function automatic logic is_invalid(input epc_class_t c);
    is_invalid = (c == EPC_CL_PSEUDO_NAN) || (c == EPC_CL_PSEUDO_INF) ||
                 (c == EPC_CL_UNNORMAL);
  endfunction

  assign escape_hit = (opcode_byte >= EPC_ESCAPE_LO) && (opcode_byte <= EPC_ESCAPE_HI);
  // empty registers hold unknown data, so the one-hot, quiet-bit and pseudo-denormal flag checks only look at defined sources
  assign known_a = (src_a == EPC_SRC_MEM) ||
                   (src_a == EPC_SRC_REG && !reg_empty[phys(stack_top, idx_a)]);
  assign known_b = (src_b == EPC_SRC_MEM) ||
                   (src_b == EPC_SRC_REG && !reg_empty[phys(stack_top, idx_b)]);
  assign use_a = (num_ops != 2'h0);
  assign use_b = (num_ops == 2'h2);
  assign val_a = (src_a == EPC_SRC_MEM) ? mem_a : regs[phys(stack_top, idx_a)];
  assign val_b = (src_b == EPC_SRC_MEM) ? mem_b : regs[phys(stack_top, idx_b)];
  assign bad_src = (use_a && (src_a == EPC_SRC_IMM || src_a == EPC_SRC_NONE)) ||
                   (use_b && (src_b == EPC_SRC_IMM || src_b == EPC_SRC_NONE)) ||
                   (num_ops == 2'h3);

  epc_classify u_cl_a (
    .operand(val_a),
    .op_class(cl_a),
    .pseudo_denorm(pd_a),
    .quiet(quiet_a)
  );
  epc_classify u_cl_b (
    .operand(val_b),
    .op_class(cl_b),
    .pseudo_denorm(pd_b),
    .quiet()
  );

  // a pseudo-denormal result is rewritten with the integer bit cleared
  always_comb begin
    res_fixed = res_value;
    if (res_value[EPC_SIGN_POS-1:EPC_EXP_LSB] == EPC_EXP_ZERO) begin
      res_fixed[EPC_INT_POS] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      float_escape_opcode_class <= 1'b0;
      opnd_a <= '0;
      opnd_b <= '0;
      class_a <= 8'h00;
      class_b <= 8'h00;
      invalid_exc <= 1'b0;
      denormal_exc <= 1'b0;
      source_fault <= 1'b0;
    end else begin
      out_valid <= req_valid && escape_hit && !bad_src;
      float_escape_opcode_class <= req_valid && escape_hit;
      source_fault <= req_valid && escape_hit && bad_src;
      opnd_a <= use_a ? val_a : '0;
      opnd_b <= use_b ? val_b : '0;
      class_a <= use_a ? cl_a : 8'h00;
      class_b <= use_b ? cl_b : 8'h00;
      invalid_exc <= req_valid && escape_hit && !bad_src &&
                     ((use_a && is_invalid(cl_a)) || (use_b && is_invalid(cl_b)));
      denormal_exc <= req_valid && escape_hit && !bad_src &&
                      ((use_a && cl_a == EPC_CL_DENORM) ||
                       (use_b && cl_b == EPC_CL_DENORM));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_out <= '0;
      res_out_valid <= 1'b0;
    end else begin
      res_out <= res_fixed;
      res_out_valid <= res_valid;
    end
  end

  // stack pointer: push decrements, pop increments; push wins when both assert
  always_comb begin
    next_top = stack_top;
    if (push) begin
      next_top = stack_top - 3'h1;
    end else if (pop) begin
      next_top = stack_top + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_top <= EPC_TOP_RESET;
      reg_empty <= 8'hFF;
    end else begin
      stack_top <= next_top;
      if (push) begin
        reg_empty[next_top] <= 1'b0;
      end else if (pop) begin
        reg_empty[stack_top] <= 1'b1;
      end
    end
  end

  // register contents need no reset; tags say what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      regs[next_top] <= push_value;
    end
  end

  a_esc_decode: assert property (@(posedge clk) disable iff (!rst_n)
    req_valid |=> float_escape_opcode_class == ($past(opcode_byte[7:3]) == 5'h1B))
    else $error("escape class mismatch");
  a_imm_refused: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && escape_hit && use_a && src_a == EPC_SRC_IMM) |=> source_fault && !out_valid)
    else $error("immediate source accepted");
  a_invalid_pnan: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && escape_hit && !bad_src && use_a && cl_a == EPC_CL_PSEUDO_NAN) |=> invalid_exc)
    else $error("pseudo-NaN without invalid");
  a_pinf_class: assert property (@(posedge clk) disable iff (!rst_n)
    (val_a[78:64] == 15'h7FFF && !val_a[63] && val_a[62:0] == '0) |-> cl_a == EPC_CL_PSEUDO_INF)
    else $error("pseudo-infinity misclassified");
  a_pnan_class: assert property (@(posedge clk) disable iff (!rst_n)
    (val_a[78:64] == 15'h7FFF && !val_a[63] && val_a[62:0] != '0) |-> cl_a == EPC_CL_PSEUDO_NAN)
    else $error("pseudo-NaN misclassified");
  a_unnorm_class: assert property (@(posedge clk) disable iff (!rst_n)
    (val_a[78:64] != 15'h7FFF && val_a[78:64] != 15'h0 && !val_a[63]) |-> cl_a == EPC_CL_UNNORMAL)
    else $error("unnormal misclassified");
  a_pdenorm_exc: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && escape_hit && !bad_src && num_ops == 2'h1 && pd_a)
      |=> denormal_exc && !invalid_exc)
    else $error("pseudo-denormal wrong exception");
  a_pdenorm_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && known_a) |-> pd_a == (val_a[78:64] == 15'h0 && val_a[63]))
    else $error("pseudo-denormal flag wrong");
  a_no_pdenorm_out: assert property (@(posedge clk) disable iff (!rst_n)
    res_out_valid |-> !(res_out[78:64] == 15'h0 && res_out[63]))
    else $error("pseudo-denormal result");
  a_pop_top: assert property (@(posedge clk) disable iff (!rst_n)
    (pop && !push) |=> stack_top == $past(stack_top) + 3'h1 && reg_empty[$past(stack_top)])
    else $error("pop did not advance top");
  a_rel_index: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && escape_hit && !bad_src && use_a && src_a == EPC_SRC_REG)
      |=> opnd_a == $past(regs[phys(stack_top, idx_a)]))
    else $error("register not stack-relative");
  a_one_hot_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && known_a) |-> $onehot(cl_a))
    else $error("class a not one-hot");
  a_one_hot_b: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && known_b) |-> $onehot(cl_b))
    else $error("class b not one-hot");
  a_pnan_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && known_a && cl_a == EPC_CL_PSEUDO_NAN) |-> quiet_a == val_a[62])
    else $error("pseudo-NaN quiet bit lost");
  a_count_refused: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && escape_hit && num_ops == 2'h3) |=> source_fault && !out_valid && !invalid_exc)
    else $error("operand count three accepted");
  a_push_top: assert property (@(posedge clk) disable iff (!rst_n)
    push |=> stack_top == $past(stack_top) - 3'h1 && !reg_empty[stack_top])
    else $error("push did not lower top");
  a_denorm_b: assert property (@(posedge clk) disable iff (!rst_n)
    (req_valid && escape_hit && !bad_src && use_b && cl_b == EPC_CL_DENORM) |=> denormal_exc)
    else $error("second denormal operand missed");
endmodule

// >>> sim/epc_dec_model.sv
module epc_dec_model
  import epc_pkg::*;
(
  // clock
  input wire logic clk,
  // request to the screen
  output logic req_valid,
  output logic [7:0] opcode_byte,
  output logic [1:0] num_ops,
  output logic [1:0] src_a,
  output logic [1:0] src_b,
  output logic [2:0] idx_a,
  output logic [2:0] idx_b,
  output logic [79:0] mem_a,
  output logic [79:0] mem_b
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {req_valid, opcode_byte, num_ops, src_a, src_b, idx_a, idx_b} = '0;
    mem_a = '0;
    mem_b = '0;
  end
  // memory words arrive already widened to the full format
  task automatic issue(input logic [7:0] op, input logic [1:0] n, input logic [1:0] sa,
                       input logic [1:0] sb, input logic [2:0] ia, input logic [79:0] ma,
                       input logic [79:0] mb);
    @(posedge clk);
    req_valid <= 1'b1;
    opcode_byte <= op;
    num_ops <= n;
    src_a <= sa;
    src_b <= sb;
    idx_a <= ia;
    idx_b <= ia;
    mem_a <= ma;
    mem_b <= mb;
    @(posedge clk);
    req_valid <= 1'b0;
    // released lines show the inverse, so a stale capture cannot pass
    mem_a <= ~ma;
    mem_b <= ~mb;
    #1;
  endtask
endmodule

// >>> sim/testbench.sv
module testbench;
  import epc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, push, pop, res_valid;
  logic [79:0] push_value, res_value, opnd_a, opnd_b, res_out;
  logic req_valid, out_valid, escape_cls, invalid_exc, denormal_exc, source_fault, res_out_valid;
  logic [7:0] opcode_byte, class_a, class_b, reg_empty;
  logic [1:0] num_ops, src_a, src_b;
  logic [2:0] idx_a, idx_b, stack_top;
  logic [79:0] mem_a, mem_b;
  int num_errors, checked, cycles;
  localparam logic [79:0] V[8] = '{80'h7FFF_4000_0000_0000_0000, 80'hFFFF_0000_0000_0000_0001,
    80'h7FFF_0000_0000_0000_0000, 80'hFFFF_0000_0000_0000_0000, 80'h0001_0000_0000_0000_0000,
    80'hFFFE_3FFF_FFFF_FFFF_FFFF, 80'h8000_8000_0000_0000_0001, 80'h3FFF_8000_0000_0000_0000};
  localparam logic [7:0] C[8] = '{8'h20, 8'h20, 8'h40, 8'h40, 8'h80, 8'h80, 8'h02, 8'h04};
  epc_dec_model partner (.clk(clk), .req_valid(req_valid), .opcode_byte(opcode_byte),
    .num_ops(num_ops), .src_a(src_a), .src_b(src_b), .idx_a(idx_a), .idx_b(idx_b),
    .mem_a(mem_a), .mem_b(mem_b));
  epc_operand_screen dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
    .opcode_byte(opcode_byte), .num_ops(num_ops), .src_a(src_a), .src_b(src_b),
    .idx_a(idx_a), .idx_b(idx_b), .mem_a(mem_a), .mem_b(mem_b), .push(push),
    .push_value(push_value), .pop(pop), .res_valid(res_valid), .res_value(res_value),
    .out_valid(out_valid), .float_escape_opcode_class(escape_cls), .opnd_a(opnd_a),
    .opnd_b(opnd_b), .class_a(class_a), .class_b(class_b), .invalid_exc(invalid_exc),
    .denormal_exc(denormal_exc), .source_fault(source_fault), .res_out(res_out),
    .res_out_valid(res_out_valid), .stack_top(stack_top), .reg_empty(reg_empty));
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // both slots carry mirrored entries so each of the five classes in the table is seen in each slot; zero, NaN and infinity are not driven
  task automatic t_classes();
    for (int i = 0; i < 8; i++) begin
      partner.issue(8'hD9, 2'h2, EPC_SRC_MEM, EPC_SRC_MEM, 3'h0, V[i], V[7-i]);
      chk(class_a, C[i]);
      chk(class_b, C[7-i]);
      chk(invalid_exc, C[i] > 8'h10 || C[7-i] > 8'h10);
      chk(denormal_exc, C[i] == 8'h02 || C[7-i] == 8'h02);
      chk(opnd_a, V[i]);
      chk(opnd_b, V[7-i]);
    end
    partner.issue(8'hDD, 2'h1, EPC_SRC_MEM, EPC_SRC_NONE, 3'h0, V[6], V[0]);
    chk({out_valid, class_a, class_b, invalid_exc, denormal_exc},
        {1'b1, 8'h02, 8'h00, 1'b0, 1'b1});
  endtask
  task automatic t_escape();
    logic [7:0] ops[4] = '{8'hD7, 8'hD8, 8'hDF, 8'hE0};
    for (int i = 0; i < 4; i++) begin
      partner.issue(ops[i], 2'h1, EPC_SRC_MEM, EPC_SRC_NONE, 3'h0, V[0], V[0]);
      chk({escape_cls, out_valid, invalid_exc}, {3{i == 1 || i == 2}});
    end
  endtask
  task automatic t_sources();
    partner.issue(8'hD8, 2'h1, EPC_SRC_IMM, EPC_SRC_NONE, 3'h0, V[0], V[0]);
    chk({source_fault, out_valid, invalid_exc}, 3'h4);
    partner.issue(8'hD8, 2'h1, EPC_SRC_NONE, EPC_SRC_NONE, 3'h0, V[0], V[0]);
    chk({source_fault, out_valid, invalid_exc}, 3'h4);
    partner.issue(8'hD8, 2'h3, EPC_SRC_MEM, EPC_SRC_MEM, 3'h0, V[0], V[0]);
    chk({source_fault, out_valid, invalid_exc}, 3'h4);
  endtask
  task automatic t_stack();
    @(posedge clk);
    push <= 1'b1;
    push_value <= V[7];
    @(posedge clk);
    push <= 1'b0;
    #1;
    chk({stack_top, reg_empty}, {3'h7, 8'h7F});
    partner.issue(8'hD9, 2'h1, EPC_SRC_REG, EPC_SRC_NONE, 3'h0, V[0], V[0]);
    chk({opnd_a, class_a, invalid_exc}, {V[7], 8'h04, 1'b0});
    // push and pop together: the push is taken
    @(posedge clk);
    {push, pop} <= 2'h3;
    push_value <= V[0];
    @(posedge clk);
    {push, pop} <= 2'h0;
    #1;
    chk({stack_top, reg_empty}, {3'h6, 8'h3F});
    partner.issue(8'hD9, 2'h1, EPC_SRC_REG, EPC_SRC_NONE, 3'h1, V[0], V[0]);
    chk({opnd_a, class_a, invalid_exc}, {V[7], 8'h04, 1'b0});
    repeat (2) begin
      @(posedge clk);
      pop <= 1'b1;
      @(posedge clk);
      pop <= 1'b0;
    end
    #1;
    chk({stack_top, reg_empty}, {3'h0, 8'hFF});
  endtask
  task automatic t_result();
    @(posedge clk);
    res_valid <= 1'b1;
    res_value <= 80'h8000_8000_0000_0000_0005;
    @(posedge clk);
    res_valid <= 1'b0;
    #1;
    chk({res_out_valid, res_out}, {1'b1, 80'h8000_0000_0000_0000_0005});
    @(posedge clk);
    #1;
    chk(res_out_valid, 1'b0);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    {rst_n, push, pop, res_valid} = '0;
    push_value = '0;
    res_value = '0;
    repeat (20) @(posedge clk);
    chk({stack_top, reg_empty, out_valid}, {3'h0, 8'hFF, 1'b0});
    rst_n <= 1'b1;
    t_classes();
    t_escape();
    t_sources();
    t_stack();
    t_result();
    report_and_stop();
  end
endmodule
